//--- dv/teletext_vbi_inserter_bench.sv
// Self-checking bench of the teletext inserter with a source model.
// Assumes the AHB-Lite slave is the only one on the bus.
module teletext_vbi_inserter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        hsync_lead, field_odd, ttx, on_line, req;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, seed, rd;
   logic [9:0]  line_number, cvbs_in, vbs_in, cvbs_out, vbs_out, pc, pv, d;
   int          err_count, n_compared, cyc, hc, req_cnt, first_req, nz_cnt, kc, nbits, dly, t0;
   real         per;
   int          pend[$];
   logic        bitq[$];

   assign hready = hreadyout;

   tvi_top tvi_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .hsync_lead(hsync_lead), .field_odd(field_odd),
      .line_number(line_number), .cvbs_in(cvbs_in), .vbs_in(vbs_in), .cvbs_out(cvbs_out),
      .vbs_out(vbs_out), .teletext_serial_input(ttx), .bit_request_output(req));

   tvi_ttx_source #(.LAT(1)) tvi_ttx_source_i (
      .hclk(hclk), .hresetn(hresetn), .hsync_lead(hsync_lead),
      .bit_request_output(req), .teletext_serial_input(ttx));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // One single AHB-Lite transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // Random video samples low enough that the added level never saturates.
   always @(posedge hclk) begin
      seed = xs(seed);
      cvbs_in <= seed[9:0] % 10'h310;
      vbs_in  <= seed[25:16] % 10'h310;
      cyc++;
      if (cyc == 70000) begin
         err_count++;
         stop_test();
      end
   end

   // Counts requests, samples the source like the block, checks inserted levels.
   always @(negedge hclk) begin
      if (hresetn) begin
         hc++;
         if (on_line) begin
            if (req === 1'b1) begin
               req_cnt++;
               if (first_req < 0) first_req = hc;
               pend.push_back(hc + dly + 1);
            end
            if (pend.size() > 0 && pend[0] == hc) begin
               bitq.push_back(ttx);
               void'(pend.pop_front());
            end
            d = cvbs_out - pc;
            chk(32'(d), 32'(10'(vbs_out - pv)));
            if (d != 10'h000) nz_cnt++;
            if (kc < nbits && hc == t0 + int'((kc + 0.5) * per)) begin
               chk(32'(d), (kc < bitq.size() && bitq[kc] === 1'b1) ? 32'h0F0 : 32'h000);
               kc++;
            end
         end
         if (hsync_lead === 1'b1) hc = -1;
         pc = cvbs_in;
         pv = vbs_in;
      end
   end

   // Programs start at random and delay at random (fixed at 1 in mode 2), runs one line and checks its counts.
   task automatic run_line(input int mode, input logic [31:0] ctrl, input logic odd,
                           input int ln, input int len, input int exp);
      int st;
      st  = 1000 + int'(seed[9:0]) % 800;
      dly = (mode == 2) ? 1 : int'(seed[19:16]) + 1;
      bus(1'b1, 32'h04, 32'(st));
      bus(1'b1, 32'h08, 32'(dly));
      bus(1'b1, 32'h00, ctrl);
      per   = (mode == 0) ? 200.0 / 6.9375 : 200.0 / 5.7272;
      t0    = ((mode == 0) ? 9780 : 10500) / 5 + 1;
      nbits = exp;
      kc = 0;
      req_cnt = 0;
      nz_cnt = 0;
      first_req = -1;
      bitq.delete();
      pend.delete();
      hsync_lead  <= 1'b1;
      field_odd   <= odd;
      line_number <= 10'(ln);
      on_line     <= 1'b1;
      @(posedge hclk);
      hsync_lead <= 1'b0;
      repeat (len) @(posedge hclk);
      on_line <= 1'b0;
      chk(32'(req_cnt), 32'(exp));
      if (exp > 0) begin
         chk(32'(first_req >= st + 1 && first_req <= st + 4), 32'h1);
      end else begin
         chk(32'(nz_cnt), 32'h0);
      end
      $display("line done: mode %0d ctrl %h requests %0d", mode, ctrl, req_cnt);
   endtask : run_line

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = 32'h0; hsync_lead = 1'b0; field_odd = 1'b0;
      line_number = 10'h000; cvbs_in = 10'h000; vbs_in = 10'h000; seed = 32'h4D4FCDCA;
      err_count = 0; n_compared = 0; cyc = 0; hc = 0; on_line = 1'b0; dly = 0;
      nbits = 0; kc = 0; pc = 10'h000; pv = 10'h000; per = 1.0; t0 = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      for (int a = 0; a <= 24; a += 4) begin
         if (a != 20) begin
            bus(1'b0, 32'(a), 32'h0);
            chk(rd, 32'h0);
         end
      end
      bus(1'b1, 32'h18, 32'hFFFFFFFF);
      bus(1'b0, 32'h18, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 32'h0C, 32'h000C000A);
      bus(1'b1, 32'h10, 32'h00160014);
      bus(1'b0, 32'h0C, 32'h0);
      chk(rd, 32'h000C000A);
      $display("register test done");
      run_line(0, 32'h3, 1'b1, 12, 12800, 360);
      run_line(1, 32'h7, 1'b0, 20, 12800, 296);
      run_line(2, 32'hB, 1'b1, 10, 12800, 288);
      run_line(0, 32'h3, 1'b1, 13, 4000, 0);
      run_line(0, 32'h3, 1'b0, 12, 4000, 0);
      run_line(0, 32'h2, 1'b1, 11, 4000, 0);
      run_line(0, 32'h1, 1'b1, 11, 4000, 0);
      stop_test();
   end
endmodule : teletext_vbi_inserter_bench

//--- dv/tvi_ttx_source.sv
// Model of the serial teletext source that answers bit requests.
// Assumes one-cycle request pulses on hclk and a line start pulse.
module tvi_ttx_source #(
   parameter int LAT = 1
) (
   // Clock and reset.
   input  wire logic hclk,
   input  wire logic hresetn,
   // Line start and bit handshake.
   input  wire logic hsync_lead,
   input  wire logic bit_request_output,
   output logic      teletext_serial_input
);
   logic [7:0]  pend_q;
   logic [15:0] lfsr_q;
   logic        first_q;

   // Delays each request by LAT cycles to mimic the source pipeline.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= 8'h00;
      end else begin
         pend_q <= {pend_q[6:0], bit_request_output};
      end
   end

   // Puts one new bit out per request; the first bit of a line is one.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfsr_q                <= 16'hACE1;
         first_q               <= 1'b1;
         teletext_serial_input <= 1'b0;
      end else if (hsync_lead) begin
         first_q <= 1'b1;
      end else if (pend_q[LAT-1]) begin
         teletext_serial_input <= first_q | lfsr_q[0];
         lfsr_q                <= {lfsr_q[0] ^ lfsr_q[2] ^ lfsr_q[3] ^ lfsr_q[5], lfsr_q[15:1]};
         first_q               <= 1'b0;
      end
   end
endmodule : tvi_ttx_source

//--- shared/tvi_params.svh
// Constants of the teletext inserter: offsets, field positions, timing counts.
// Assumes a 200 MHz hclk and a 10-bit video sample path.
// What this block does
// - Inserted data starts 9.78 us (PAL) or 10.5 us (NTSC) after sync lead.
// - Interpolated teletext bits are added to composite and luma-plus-sync outputs.
// - Input is sampled the programmed delay plus one cycle after each request rise; source meets it.
// - Software sets the delay that absorbs source latency without moving insertion.
// - The request train starts at a software-programmed position after sync.
// - PAL mode window holds 360 bits at 6.9375 Mbit/s.
// - World-standard 525-line mode window holds 296 bits at 5.7272 Mbit/s.
// - NABTS mode window holds 288 bits at 5.7272 Mbit/s.
// - The window stays closed and nothing is inserted while enable is zero.
// - Odd-field lines from programmed first through last line carry teletext.
// - Even-field lines from their own first through last line carry teletext.
// - Teletext pins work only when selected by the control register.
`ifndef TVI_PARAMS_SVH
`define TVI_PARAMS_SVH

`define TVI_CLK_NS         5
`define TVI_CLK_HZ         64'd200000000
`define TVI_T_TTX_PAL_NS   9780
`define TVI_T_TTX_NTSC_NS  10500
`define TVI_TTX_PAL_CYC    12'(`TVI_T_TTX_PAL_NS / `TVI_CLK_NS)
`define TVI_TTX_NTSC_CYC   12'(`TVI_T_TTX_NTSC_NS / `TVI_CLK_NS)
`define TVI_INS_LAT        12'h003
`define TVI_BITS_PAL       9'h168
`define TVI_BITS_WST       9'h128
`define TVI_BITS_NABTS     9'h120
`define TVI_RATE_PAL_BPS   64'd6937500
`define TVI_RATE_NTSC_BPS  64'd5727200
`define TVI_ACC_W          24
`define TVI_ACC_ONE        64'h1000000
`define TVI_INC_PAL        24'((`TVI_RATE_PAL_BPS * `TVI_ACC_ONE) / `TVI_CLK_HZ)
`define TVI_INC_NTSC       24'((`TVI_RATE_NTSC_BPS * `TVI_ACC_ONE) / `TVI_CLK_HZ)
`define TVI_TTX_LEVEL      10'h0F0
`define TVI_FIFO_W         1
`define TVI_FIFO_D         8
`define TVI_CREDIT_FULL    4'h8
`define TVI_REG_CTRL       8'h00
`define TVI_REG_START      8'h04
`define TVI_REG_DELAY      8'h08
`define TVI_REG_ODD        8'h0C
`define TVI_REG_EVEN       8'h10
`define TVI_REG_STATUS     8'h14
`define TVI_CTRL_EN        0
`define TVI_CTRL_PSEL      1
`define TVI_CTRL_MODE      3:2
`define TVI_START_F        11:0
`define TVI_DELAY_F        7:0
`define TVI_FIRST_F        9:0
`define TVI_LAST_F         25:16
`define TVI_RST_START      12'h000
`define TVI_RST_DELAY      8'h00
`define TVI_RST_LINE       10'h000

`endif

//--- shared/tvi_pkg.sv
// Types shared by the teletext inserter modules.
// Assumes nothing of its surroundings.
package tvi_pkg;
   typedef enum logic [1:0] {TVI_PAL, TVI_WST525, TVI_NABTS} tvi_mode_t;
endpackage : tvi_pkg

//--- src/tvi_fifo.sv
// Small FIFO for sampled teletext bits.
// Assumes one clock; flush empties it in one cycle.
module tvi_fifo #(
   parameter int W = 1,
   parameter int D = 8
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   // Filling side.
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side.
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = cnt_q != (AW+1)'(D);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : tvi_fifo

//--- src/tvi_rate_gen.sv
// Phase accumulator that marks teletext bit slots.
// Assumes inc is steady while run is high.
`include "tvi_params.svh"
module tvi_rate_gen (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Control.
   input  wire logic                  start,
   input  wire logic                  run,
   input  wire logic [`TVI_ACC_W-1:0] inc,
   // Bit slot pulse.
   output logic                       tick
);
   logic [`TVI_ACC_W-1:0] acc_q;
   logic [`TVI_ACC_W:0]   sum;

   assign sum = {1'b0, acc_q} + {1'b0, inc};

   // Start presets the phase so the first slot follows at once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
         tick  <= 1'b0;
      end else if (start) begin
         acc_q <= '1;
         tick  <= 1'b0;
      end else if (run) begin
         acc_q <= sum[`TVI_ACC_W-1:0];
         tick  <= sum[`TVI_ACC_W];
      end else begin
         tick  <= 1'b0;
      end
   end
endmodule : tvi_rate_gen

//--- src/tvi_top.sv
// Teletext inserter: request train, input sampling, insertion into video.
// Assumes an AHB-Lite master on hclk and a one-cycle sync-lead pulse.
`include "tvi_params.svh"
module tvi_top (
   // AHB-Lite slave.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Video timing.
   input  wire logic        hsync_lead,
   input  wire logic        field_odd,
   input  wire logic [9:0]  line_number,
   // Video path.
   input  wire logic [9:0]  cvbs_in,
   input  wire logic [9:0]  vbs_in,
   output logic [9:0]       cvbs_out,
   output logic [9:0]       vbs_out,
   // Teletext pins.
   input  wire logic        teletext_serial_input,
   output logic             bit_request_output
);
   tvi_pkg::tvi_mode_t    mode_q;
   logic                  insertion_enable_q;
   logic                  pin_sel_q;
   logic [11:0]           request_start_position_q;
   logic [7:0]            request_to_data_delay_q;
   logic [9:0]            odd_field_first_line_q;
   logic [9:0]            odd_field_last_line_q;
   logic [9:0]            even_field_first_line_q;
   logic [9:0]            even_field_last_line_q;
   logic                  bus_acc;
   logic                  wr_pend_q;
   logic [7:0]            wr_addr_q;
   logic [31:0]           rd_d;
   logic [11:0]           h_cnt_q;
   logic                  line_en_q;
   logic [11:0]           ttx_cyc;
   logic [8:0]            nbits;
   logic [`TVI_ACC_W-1:0] inc;
   logic                  req_start;
   logic                  req_active_q;
   logic [8:0]            req_cnt_q;
   logic                  req_tick;
   logic [3:0]            credit_q;
   logic [255:0]          req_sr_q;
   logic                  smp_fire;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_out_data;
   logic                  fifo_pop;
   logic                  ins_start;
   logic                  ins_active_q;
   logic [8:0]            ins_cnt_q;
   logic                  ins_tick;
   logic                  cur_lvl_q;
   logic                  prev_lvl_q;
   logic [9:0]            lvl;

   function automatic logic [9:0] sat_add(input logic [9:0] a, input logic [9:0] b);
      logic [10:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[10] ? 10'h3FF : s[9:0];
   endfunction : sat_add

   // Bus slave: zero wait states, always OKAY.
   assign bus_acc = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= bus_acc & hwrite;
         wr_addr_q <= haddr[7:0];
         hrdata    <= (bus_acc & ~hwrite) ? rd_d : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      case (haddr[7:0])
         `TVI_REG_CTRL: begin
            rd_d[`TVI_CTRL_EN]   = insertion_enable_q;
            rd_d[`TVI_CTRL_PSEL] = pin_sel_q;
            rd_d[`TVI_CTRL_MODE] = mode_q;
         end
         `TVI_REG_START: rd_d[`TVI_START_F] = request_start_position_q;
         `TVI_REG_DELAY: rd_d[`TVI_DELAY_F] = request_to_data_delay_q;
         `TVI_REG_ODD: begin
            rd_d[`TVI_FIRST_F] = odd_field_first_line_q;
            rd_d[`TVI_LAST_F]  = odd_field_last_line_q;
         end
         `TVI_REG_EVEN: begin
            rd_d[`TVI_FIRST_F] = even_field_first_line_q;
            rd_d[`TVI_LAST_F]  = even_field_last_line_q;
         end
         `TVI_REG_STATUS: rd_d[4:0] = {fifo_out_valid, ins_active_q, req_active_q,
                                       line_en_q, fifo_in_ready};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         insertion_enable_q       <= 1'b0;
         pin_sel_q                <= 1'b0;
         mode_q                   <= tvi_pkg::TVI_PAL;
         request_start_position_q <= `TVI_RST_START;
         request_to_data_delay_q  <= `TVI_RST_DELAY;
         odd_field_first_line_q   <= `TVI_RST_LINE;
         odd_field_last_line_q    <= `TVI_RST_LINE;
         even_field_first_line_q  <= `TVI_RST_LINE;
         even_field_last_line_q   <= `TVI_RST_LINE;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            `TVI_REG_CTRL: begin
               insertion_enable_q <= hwdata[`TVI_CTRL_EN];
               pin_sel_q          <= hwdata[`TVI_CTRL_PSEL];
               mode_q             <= tvi_pkg::tvi_mode_t'(hwdata[`TVI_CTRL_MODE]);
            end
            `TVI_REG_START: request_start_position_q <= hwdata[`TVI_START_F];
            `TVI_REG_DELAY: request_to_data_delay_q <= hwdata[`TVI_DELAY_F];
            `TVI_REG_ODD: begin
               odd_field_first_line_q <= hwdata[`TVI_FIRST_F];
               odd_field_last_line_q  <= hwdata[`TVI_LAST_F];
            end
            `TVI_REG_EVEN: begin
               even_field_first_line_q <= hwdata[`TVI_FIRST_F];
               even_field_last_line_q  <= hwdata[`TVI_LAST_F];
            end
            default: ;
         endcase
      end
   end

   // Standard selection.
   always_comb begin
      case (mode_q)
         tvi_pkg::TVI_WST525: begin
            ttx_cyc = `TVI_TTX_NTSC_CYC;
            nbits   = `TVI_BITS_WST;
            inc     = `TVI_INC_NTSC;
         end
         tvi_pkg::TVI_NABTS: begin
            ttx_cyc = `TVI_TTX_NTSC_CYC;
            nbits   = `TVI_BITS_NABTS;
            inc     = `TVI_INC_NTSC;
         end
         default: begin
            ttx_cyc = `TVI_TTX_PAL_CYC;
            nbits   = `TVI_BITS_PAL;
            inc     = `TVI_INC_PAL;
         end
      endcase
   end

   // Line timing and per-line enable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         h_cnt_q <= 12'h000;
      end else if (hsync_lead) begin
         h_cnt_q <= 12'h000;
      end else if (h_cnt_q != 12'hFFF) begin
         h_cnt_q <= h_cnt_q + 12'h001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_en_q <= 1'b0;
      end else if (!insertion_enable_q || !pin_sel_q) begin
         line_en_q <= 1'b0;
      end else if (hsync_lead) begin
         line_en_q <= field_odd ?
            (line_number >= odd_field_first_line_q &&
             line_number <= odd_field_last_line_q) :
            (line_number >= even_field_first_line_q &&
             line_number <= even_field_last_line_q);
      end
   end

   // Request train.
   assign req_start = line_en_q & ~hsync_lead & (h_cnt_q == request_start_position_q);

   tvi_rate_gen u_req_rate (
      .clk   (hclk),
      .rst_n (hresetn),
      .start (req_start),
      .run   (req_active_q & fifo_in_ready & (credit_q != 4'h0)),
      .inc   (inc),
      .tick  (req_tick)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_active_q       <= 1'b0;
         req_cnt_q          <= 9'h000;
         bit_request_output <= 1'b0;
      end else begin
         bit_request_output <= req_active_q & req_tick & line_en_q;
         if (hsync_lead || !line_en_q) begin
            req_active_q <= 1'b0;
         end else if (req_start) begin
            req_active_q <= 1'b1;
            req_cnt_q    <= 9'h000;
         end else if (req_active_q && req_tick) begin
            req_cnt_q <= req_cnt_q + 9'h001;
            if (req_cnt_q + 9'h001 == nbits) begin
               req_active_q <= 1'b0;
            end
         end
      end
   end

   // Free FIFO slots minus requests in flight keep the FIFO from overflowing.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         credit_q <= `TVI_CREDIT_FULL;
      end else if (hsync_lead) begin
         credit_q <= `TVI_CREDIT_FULL;
      end else begin
         credit_q <= credit_q - 4'(bit_request_output) + 4'(fifo_pop);
      end
   end

   // Input sampling after the programmed delay.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_sr_q <= '0;
      end else if (hsync_lead) begin
         req_sr_q <= '0;
      end else begin
         req_sr_q <= {req_sr_q[254:0], bit_request_output};
      end
   end

   assign smp_fire = req_sr_q[request_to_data_delay_q];

   assign fifo_pop = ins_active_q & ins_tick;

   tvi_fifo #(
      .W (`TVI_FIFO_W),
      .D (`TVI_FIFO_D)
   ) u_fifo (
      .clk       (hclk),
      .rst_n     (hresetn),
      .flush     (hsync_lead),
      .in_valid  (smp_fire),
      .in_ready  (fifo_in_ready),
      .in_data   (teletext_serial_input),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // Insertion window.
   assign ins_start = line_en_q & ~hsync_lead & (h_cnt_q == ttx_cyc - `TVI_INS_LAT);

   tvi_rate_gen u_ins_rate (
      .clk   (hclk),
      .rst_n (hresetn),
      .start (ins_start),
      .run   (ins_active_q),
      .inc   (inc),
      .tick  (ins_tick)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ins_active_q <= 1'b0;
         ins_cnt_q    <= 9'h000;
         cur_lvl_q    <= 1'b0;
         prev_lvl_q   <= 1'b0;
      end else if (hsync_lead || !line_en_q || (fifo_pop && ins_cnt_q == nbits)) begin
         ins_active_q <= 1'b0;
         cur_lvl_q    <= 1'b0;
         prev_lvl_q   <= 1'b0;
      end else begin
         prev_lvl_q <= cur_lvl_q;
         if (ins_start) begin
            ins_active_q <= 1'b1;
            ins_cnt_q    <= 9'h000;
         end else if (fifo_pop) begin
            cur_lvl_q <= fifo_out_valid & fifo_out_data;
            ins_cnt_q <= ins_cnt_q + 9'h001;
         end
      end
   end

   // Two-tap interpolation softens each bit edge.
   assign lvl = (cur_lvl_q ? (`TVI_TTX_LEVEL >> 1) : 10'h000) +
                (prev_lvl_q ? (`TVI_TTX_LEVEL >> 1) : 10'h000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cvbs_out <= 10'h000;
         vbs_out  <= 10'h000;
      end else begin
         cvbs_out <= sat_add(cvbs_in, lvl);
         vbs_out  <= sat_add(vbs_in, lvl);
      end
   end

   // Checks.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_REQ_IN_WINDOW: assert property (bit_request_output |-> $past(req_active_q))
      else $error("Request outside the request window.");
   AST_REQ_ONE_CYCLE: assert property (bit_request_output |=> !bit_request_output)
      else $error("Request high for more than one cycle.");
   AST_REQ_COUNT: assert property (req_cnt_q <= nbits || !req_active_q)
      else $error("More requests than bit slots.");
   AST_REQ_START: assert property (req_start |=> req_active_q ##1 !bit_request_output)
      else $error("Request train did not start at the programmed position.");
   AST_DELAY1: assert property (bit_request_output && request_to_data_delay_q == 8'h01
      && !hsync_lead ##1 !hsync_lead |=> smp_fire)
      else $error("Sample not taken two cycles after request.");
   AST_INS_START: assert property (ins_start && !$past(hsync_lead) |=> ins_active_q)
      else $error("Insertion did not open at the sync offset.");
   AST_DISABLED: assert property (!insertion_enable_q |=> !line_en_q ##1 !ins_active_q)
      else $error("Window open while insertion is disabled.");
   AST_PINS: assert property (!pin_sel_q |=> ##1 !bit_request_output)
      else $error("Request driven while pins are not selected.");
   AST_ODD_RANGE: assert property (hsync_lead && field_odd &&
      (line_number < odd_field_first_line_q || line_number > odd_field_last_line_q)
      |=> !line_en_q)
      else $error("Odd line outside its range enabled.");
   AST_EVEN_RANGE: assert property (hsync_lead && !field_odd &&
      (line_number < even_field_first_line_q || line_number > even_field_last_line_q)
      |=> !line_en_q)
      else $error("Even line outside its range enabled.");
   AST_CLOSE: assert property (fifo_pop && ins_cnt_q == nbits && !hsync_lead
      |=> !ins_active_q)
      else $error("Window length wrong.");
   AST_QUIET: assert property ($past(hresetn) && !$past(ins_active_q)
      && !$past(cur_lvl_q) && !$past(prev_lvl_q)
      |-> cvbs_out == $past(cvbs_in) && vbs_out == $past(vbs_in))
      else $error("Video changed outside insertion.");

   COV_PAL_WINDOW: cover property (mode_q == tvi_pkg::TVI_PAL && ins_start);
   COV_FIFO_FULL: cover property (!fifo_in_ready);
   COV_FULL_LINE: cover property (fifo_pop && ins_cnt_q == nbits);
endmodule : tvi_top
